// ==== hdl/driver_ctrl_status_map.vh ====
// Bit positions, reset values and timing counts for control/status word one
`ifndef DRIVER_CTRL_STATUS_MAP_VH
`define DRIVER_CTRL_STATUS_MAP_VH

// Serial frame layout
`define FRAME_BITS          5'h18
`define FRAME_CNT_W         5
`define WORD_SEL_BIT        0
`define WORD_SEL_ONE        1'b1

// Control word one fields
`define CTRL1_ENABLE_BIT    23
`define CTRL1_RETRY_HI      22
`define CTRL1_RETRY_LO      18
`define CTRL1_RETRY_RST     5'h00
`define CTRL1_ENABLE_RST    1'b0

// Status word one fields
`define STAT1_ALWAYS_ONE    1'b1
`define STAT1_OV_BIT        22
`define STAT1_UV_BIT        21
`define STAT1_TSD_BIT       20
`define STAT1_TWARN_BIT     19
`define STAT1_NRDY_BIT      18

// Status word zero fields held here
`define STAT0_TOP_BIT_VAL   1'b1
`define STAT0_OC_HI         17
`define STAT0_OC_LO         13

// Timing
`define CLK_PERIOD_NS       4
`define STARTUP_TIME_US     100
`define STARTUP_CYCLES      ((`STARTUP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define RETRY_LONG_US       40
`define RETRY_LONG_CYCLES   ((`RETRY_LONG_US * 1000) / `CLK_PERIOD_NS)
`define RETRY_SHORT_US      10
`define RETRY_SHORT_CYCLES  ((`RETRY_SHORT_US * 1000) / `CLK_PERIOD_NS)
`define TMR_W               16

`endif

// ==== hdl/pin_sync3.v ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3 #(
   parameter             WIDTH   = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input  wire             sys_clk,
   input  wire             nrst,
   input  wire             clk_en,
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);
   reg  [WIDTH-1:0] stage1_ff;
   reg  [WIDTH-1:0] stage2_ff;
   reg  [WIDTH-1:0] stage3_ff;
   reg  [WIDTH-1:0] out_ff;
   genvar           i;

   // Synchroniser chain
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stage1_ff <= RST_VAL;
         stage2_ff <= RST_VAL;
         stage3_ff <= RST_VAL;
      end else if (clk_en) begin
         stage1_ff <= din;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
      end
   end

   // Accept a change once stages two and three agree
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
         always @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               out_ff[i] <= RST_VAL[i];
            end else if (clk_en && (stage2_ff[i] == stage3_ff[i])) begin
               out_ff[i] <= stage3_ff[i];
            end
         end
      end
   endgenerate

   assign dout = out_ff;
endmodule

// ==== hdl/driver_ctrl_status_reg_one.v ====
// Control word one and status word one of the load driver serial port
`timescale 1ns/10ps
`include "driver_ctrl_status_map.vh"
module driver_ctrl_status_reg_one #(
   parameter                NUM_HS         = 5,
   parameter [`TMR_W-1:0]   STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter [`TMR_W-1:0]   RETRY_LONG     = `RETRY_LONG_CYCLES,
   parameter [`TMR_W-1:0]   RETRY_SHORT    = `RETRY_SHORT_CYCLES
) (
   input  wire              sys_clk,
   input  wire              nrst,
   input  wire              clk_en,
   input  wire              spi_csn_pin,
   input  wire              spi_sclk_pin,
   input  wire              spi_mosi_pin,
   input  wire              ov_det_pin,
   input  wire              uv_det_pin,
   input  wire              tsd_det_pin,
   input  wire              twarn_det_pin,
   input  wire [NUM_HS-1:0] oc_det_pin,
   input  wire [NUM_HS-1:0] hs_on_req,
   input  wire              retry_duty_sel,
   input  wire              fault_reset,
   input  wire [22:1]       status0_ext,
   input  wire [17:1]       status1_ext,
   output wire              spi_miso,
   output wire              spi_miso_oe,
   output wire [NUM_HS-1:0] hs_drive,
   output wire              active_mode,
   output wire [NUM_HS-1:0] overcurrent_auto_retry_enable
);
   localparam SYNC_W = 7 + NUM_HS;
   localparam [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-1){1'b0}}, 1'b1};
   localparam [`FRAME_CNT_W-1:0] FRAME_LEN = `FRAME_BITS;

   wire [SYNC_W-1:0]        sync_out;
   wire                     csn_s;
   wire                     sclk_s;
   wire                     mosi_s;
   wire                     ov_s;
   wire                     uv_s;
   wire                     tsd_s;
   wire                     twarn_s;
   wire [NUM_HS-1:0]        oc_s;
   reg                      csn_d_ff;
   reg                      sclk_d_ff;
   reg  [23:0]              rx_ff;
   reg  [23:0]              tx_ff;
   reg  [`FRAME_CNT_W-1:0]  bit_cnt_ff;
   reg                      miso_ff;
   reg                      miso_oe_ff;
   reg                      sel_one_ff;
   reg                      enable_ff;
   reg  [NUM_HS-1:0]        retry_en_ff;
   reg                      ov_flag_ff;
   reg                      uv_flag_ff;
   reg                      tsd_flag_ff;
   reg                      not_ready_ff;
   reg  [`TMR_W-1:0]        start_tmr_ff;
   reg                      phase_ff;
   reg  [NUM_HS-1:0]        oc_flag_ff;
   reg  [NUM_HS-1:0]        blocked_ff;
   reg  [NUM_HS-1:0]        grant_ff;
   reg  [NUM_HS-1:0]        hs_drive_ff;
   reg  [`TMR_W*NUM_HS-1:0] retry_tmr_ff;
   wire                     csn_fall;
   wire                     csn_rise;
   wire                     sclk_rise;
   wire                     sclk_fall;
   wire                     frame_ok;
   wire                     wr_one;
   wire                     go_standby;
   wire                     standby;
   wire                     outputs_ok;
   wire                     no_error;
   wire [23:0]              status0_word;
   wire [23:0]              status1_word;
   wire [NUM_HS-1:0]        oc_ev;
   wire [`TMR_W-1:0]        retry_delay;
   genvar                   i;

   // All pins and analog detector levels come from outside the clock domain
   pin_sync3 #(
      .WIDTH   (SYNC_W),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .din     ({oc_det_pin, twarn_det_pin, tsd_det_pin, uv_det_pin,
                 ov_det_pin, spi_mosi_pin, spi_sclk_pin, spi_csn_pin}),
      .dout    (sync_out)
   );

   assign csn_s   = sync_out[0];
   assign sclk_s  = sync_out[1];
   assign mosi_s  = sync_out[2];
   assign ov_s    = sync_out[3];
   assign uv_s    = sync_out[4];
   assign tsd_s   = sync_out[5];
   assign twarn_s = sync_out[6];
   assign oc_s    = sync_out[SYNC_W-1:7];

   // Frame edge detection
   assign csn_fall  = csn_d_ff & ~csn_s;
   assign csn_rise  = ~csn_d_ff & csn_s;
   assign sclk_rise = ~sclk_d_ff & sclk_s & ~csn_s;
   assign sclk_fall = sclk_d_ff & ~sclk_s & ~csn_s;
   assign frame_ok  = csn_rise & (bit_cnt_ff == FRAME_LEN);
   assign wr_one    = frame_ok & (rx_ff[`WORD_SEL_BIT] == `WORD_SEL_ONE);
   assign go_standby = wr_one & ~rx_ff[`CTRL1_ENABLE_BIT];
   assign standby   = ~enable_ff | go_standby;

   // Status words as shifted out
   assign no_error = ~(|status0_ext[22:18] | |oc_flag_ff |
                       |status0_ext[12:1] | ov_flag_ff | uv_flag_ff |
                       tsd_flag_ff | twarn_s | not_ready_ff |
                       |status1_ext);
   assign status0_word = {`STAT0_TOP_BIT_VAL, status0_ext[22:18],
                          oc_flag_ff, status0_ext[12:1], no_error};
   assign status1_word = {`STAT1_ALWAYS_ONE, ov_flag_ff, uv_flag_ff,
                          tsd_flag_ff, twarn_s, not_ready_ff,
                          status1_ext, no_error};

   // Serial shifter: sample on SCLK rise, shift out on SCLK fall
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         csn_d_ff   <= 1'b1;
         sclk_d_ff  <= 1'b0;
         rx_ff      <= 24'h000000;
         tx_ff      <= 24'h000000;
         bit_cnt_ff <= {`FRAME_CNT_W{1'b0}};
         miso_ff    <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else if (clk_en) begin
         csn_d_ff   <= csn_s;
         sclk_d_ff  <= sclk_s;
         miso_oe_ff <= ~csn_s;
         miso_ff    <= tx_ff[23];
         if (csn_fall) begin
            tx_ff      <= sel_one_ff ? status1_word : status0_word;
            bit_cnt_ff <= {`FRAME_CNT_W{1'b0}};
         end else if (sclk_rise) begin
            rx_ff <= {rx_ff[22:0], mosi_s};
            if (bit_cnt_ff != FRAME_LEN + 5'h01) begin
               bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
         end else if (sclk_fall) begin
            tx_ff <= {tx_ff[22:0], 1'b0};
         end
      end
   end

   // Control word one and start-up timer
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sel_one_ff   <= 1'b0;
         enable_ff    <= `CTRL1_ENABLE_RST;
         retry_en_ff  <= `CTRL1_RETRY_RST;
         not_ready_ff <= 1'b0;
         start_tmr_ff <= {`TMR_W{1'b0}};
         phase_ff     <= 1'b0;
      end else if (clk_en) begin
         phase_ff <= ~phase_ff;
         if (frame_ok) begin
            sel_one_ff <= rx_ff[`WORD_SEL_BIT];
         end
         if (wr_one) begin
            enable_ff <= rx_ff[`CTRL1_ENABLE_BIT];
            retry_en_ff <= rx_ff[`CTRL1_ENABLE_BIT] ?
                           rx_ff[`CTRL1_RETRY_HI:`CTRL1_RETRY_LO] :
                           `CTRL1_RETRY_RST;
         end
         if (standby) begin
            not_ready_ff <= 1'b0;
            start_tmr_ff <= {`TMR_W{1'b0}};
            if (wr_one && rx_ff[`CTRL1_ENABLE_BIT]) begin
               not_ready_ff <= 1'b1;
               start_tmr_ff <= STARTUP_CYCLES;
            end
         end else if (start_tmr_ff != {`TMR_W{1'b0}}) begin
            start_tmr_ff <= start_tmr_ff - {{(`TMR_W-1){1'b0}}, 1'b1};
            if (start_tmr_ff == {{(`TMR_W-1){1'b0}}, 1'b1}) begin
               not_ready_ff <= 1'b0;
            end
         end
      end
   end

   // Supply and thermal flags; an event beats a fault_reset clear in the same cycle
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ov_flag_ff  <= 1'b0;
         uv_flag_ff  <= 1'b0;
         tsd_flag_ff <= 1'b0;
      end else if (clk_en) begin
         if (standby) begin
            ov_flag_ff  <= 1'b0;
            uv_flag_ff  <= 1'b0;
            tsd_flag_ff <= 1'b0;
         end else begin
            if (ov_s) begin
               ov_flag_ff <= 1'b1;
            end else if (fault_reset) begin
               ov_flag_ff <= 1'b0;
            end
            if (uv_s) begin
               uv_flag_ff <= 1'b1;
            end else if (fault_reset) begin
               uv_flag_ff <= 1'b0;
            end
            if (tsd_s) begin
               tsd_flag_ff <= 1'b1;
            end else if (fault_reset) begin
               tsd_flag_ff <= 1'b0;
            end
         end
      end
   end

   // Outputs allowed only when active, settled and free of supply faults
   assign outputs_ok = ~standby & ~not_ready_ff & ~ov_s & ~uv_s &
                       ~tsd_flag_ff;
   assign retry_delay = retry_duty_sel ? RETRY_LONG : RETRY_SHORT;

   // Per-output over-current protection and retry
   generate
      for (i = 0; i < NUM_HS; i = i + 1) begin : g_hs
         assign oc_ev[i] = oc_s[i] & hs_drive_ff[i];
         always @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               oc_flag_ff[i]  <= 1'b0;
               blocked_ff[i]  <= 1'b0;
               grant_ff[i]    <= 1'b0;
               hs_drive_ff[i] <= 1'b0;
               retry_tmr_ff[i*`TMR_W +: `TMR_W] <= {`TMR_W{1'b0}};
            end else if (clk_en) begin
               hs_drive_ff[i] <= hs_on_req[i] & outputs_ok &
                                 ~blocked_ff[i] & ~oc_ev[i];
               if (standby) begin
                  oc_flag_ff[i] <= 1'b0;
                  blocked_ff[i] <= 1'b0;
                  grant_ff[i]   <= 1'b0;
                  retry_tmr_ff[i*`TMR_W +: `TMR_W] <= {`TMR_W{1'b0}};
               end else if (oc_ev[i]) begin
                  oc_flag_ff[i] <= 1'b1;
                  blocked_ff[i] <= 1'b1;
                  grant_ff[i]   <= retry_en_ff[i] |
                                   (phase_ff & ~oc_flag_ff[i]);
                  retry_tmr_ff[i*`TMR_W +: `TMR_W] <= retry_delay;
               end else begin
                  if (fault_reset) begin
                     oc_flag_ff[i] <= 1'b0;
                     blocked_ff[i] <= 1'b0;
                  end
                  if (retry_tmr_ff[i*`TMR_W +: `TMR_W] != {`TMR_W{1'b0}}) begin
                     retry_tmr_ff[i*`TMR_W +: `TMR_W] <=
                        retry_tmr_ff[i*`TMR_W +: `TMR_W] -
                        {{(`TMR_W-1){1'b0}}, 1'b1};
                  end else if (blocked_ff[i] && grant_ff[i]) begin
                     blocked_ff[i] <= 1'b0;
                     grant_ff[i]   <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate

   assign spi_miso    = miso_ff;
   assign spi_miso_oe = miso_oe_ff;
   assign hs_drive    = hs_drive_ff;
   assign active_mode = enable_ff;
   assign overcurrent_auto_retry_enable = retry_en_ff;
endmodule

// ==== testbench/spi_host_model.sv ====
// Microcontroller side: SPI mode 0 master sending one frame per start
`timescale 1ns/10ps
module spi_host_model (
   input  wire        sys_clk,
   input  wire        start,
   input  wire [23:0] tx,
   input  wire [4:0]  nbits,
   input  wire        spi_miso,
   output reg         spi_csn_pin,
   output reg         spi_sclk_pin,
   output reg         spi_mosi_pin,
   output reg  [23:0] rx,
   output reg         done
);
   integer i;
   // Idle: deselected, clock low
   initial begin
      {spi_csn_pin, spi_sclk_pin, spi_mosi_pin, done} = 4'h9;
      rx = 24'h000000;
   end
   // Frame MSB first, eight cycles a clock phase
   always @(posedge start) begin
      done = 1'b0;
      @(posedge sys_clk) #1 spi_csn_pin = 1'b0;
      for (i = 0; i < nbits; i = i + 1) begin
         spi_mosi_pin = tx[23 - i];
         repeat (8) @(posedge sys_clk);
         #1 rx = {rx[22:0], spi_miso};
         spi_sclk_pin = 1'b1;
         repeat (8) @(posedge sys_clk);
         #1 spi_sclk_pin = 1'b0;
      end
      repeat (8) @(posedge sys_clk);
      #1 spi_csn_pin = 1'b1;
      spi_mosi_pin = ~spi_mosi_pin; // Released line shows inverse
      repeat (10) @(posedge sys_clk);
      #1 done = 1'b1;
   end
endmodule

// ==== testbench/driver_ctrl_status_chk.sv ====
// Assertions on word one control, fault gating and drive outputs
`timescale 1ns/10ps
module driver_ctrl_status_chk #(
   parameter        NUM_HS         = 5,
   parameter [15:0] STARTUP_CYCLES = 16'h0014
) (
   input wire              sys_clk,
   input wire              nrst,
   input wire              clk_en,
   input wire              spi_csn_pin,
   input wire              ov_det_pin,
   input wire              uv_det_pin,
   input wire              tsd_det_pin,
   input wire [NUM_HS-1:0] oc_det_pin,
   input wire [NUM_HS-1:0] hs_on_req,
   input wire              spi_miso_oe,
   input wire [NUM_HS-1:0] hs_drive,
   input wire              active_mode,
   input wire [NUM_HS-1:0] overcurrent_auto_retry_enable
);
   reg [15:0] up_cnt_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Cycles spent in active mode, saturating
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         up_cnt_ff <= 16'h0000;
      else if (!active_mode)
         up_cnt_ff <= 16'h0000;
      else if (clk_en && up_cnt_ff != STARTUP_CYCLES)
         up_cnt_ff <= up_cnt_ff + 16'h0001;
   end
   reset_idle_a: assert property ($rose(nrst) |-> !active_mode
      && hs_drive == 0) else $error("outputs not idle after reset");
   standby_drive_a: assert property (|hs_drive |-> active_mode)
      else $error("drive while in standby");
   req_gate_a: assert property (clk_en |=>
      (hs_drive & ~$past(hs_on_req)) == 0) else $error("unrequested drive");
   startup_hold_a: assert property (active_mode
      && up_cnt_ff < STARTUP_CYCLES |-> hs_drive == 0)
      else $error("drive before start-up time");
   ov_off_a: assert property ((clk_en && ov_det_pin)[*8]
      |-> hs_drive == 0) else $error("drive during overvoltage");
   uv_off_a: assert property ((clk_en && uv_det_pin)[*8]
      |-> hs_drive == 0) else $error("drive during undervoltage");
   tsd_off_a: assert property ((clk_en && tsd_det_pin)[*8]
      |-> hs_drive == 0) else $error("drive during thermal shutdown");
   oc_trip_a: assert property ((clk_en && oc_det_pin[0])[*5] ##1
      (clk_en && oc_det_pin[0] && hs_drive[0]) |=> !hs_drive[0])
      else $error("drive kept on over-current");
   standby_clear_a: assert property ($fell(active_mode) |->
      overcurrent_auto_retry_enable == 0) else $error("retry bits kept");
   oe_idle_a: assert property ((clk_en && spi_csn_pin)[*8]
      |-> !spi_miso_oe) else $error("miso driven while deselected");
endmodule

bind driver_ctrl_status_reg_one driver_ctrl_status_chk #(
   .NUM_HS(NUM_HS), .STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
   .sys_clk, .nrst, .clk_en, .spi_csn_pin, .ov_det_pin, .uv_det_pin,
   .tsd_det_pin, .oc_det_pin, .hs_on_req, .spi_miso_oe, .hs_drive,
   .active_mode, .overcurrent_auto_retry_enable);

// ==== testbench/tb.sv ====
// Self-checking bench for control word one and status word one
`timescale 1ns/10ps
module tb;
   reg         sys_clk, nrst, clk_en, ov_det_pin, uv_det_pin, tsd_det_pin;
   reg         twarn_det_pin, retry_duty_sel, fault_reset, start, miso_last;
   reg  [4:0]  oc_det_pin, hs_on_req, nbits;
   reg  [22:1] status0_ext;
   reg  [17:1] status1_ext;
   reg  [23:0] tx;
   reg  [29:0] rows [0:4];
   wire [23:0] rx;
   wire        spi_csn_pin, spi_sclk_pin, spi_mosi_pin, spi_miso, done;
   wire        spi_miso_oe, active_mode, miso_line;
   wire [4:0]  hs_drive, overcurrent_auto_retry_enable;
   integer     bad_count, num_checks, cycles, i;
   // Wire level seen by the host; a released line shows the inverse
   assign miso_line = spi_miso_oe ? spi_miso : ~miso_last;
   always @(posedge sys_clk) if (spi_miso_oe) miso_last <= spi_miso;
   always #2 sys_clk = ~sys_clk;
   driver_ctrl_status_reg_one #(.STARTUP_CYCLES(16'h00C8),
      .RETRY_LONG(16'h000A), .RETRY_SHORT(16'h0005)) DUT (
      .sys_clk, .nrst, .clk_en, .spi_csn_pin, .spi_sclk_pin, .spi_mosi_pin,
      .ov_det_pin, .uv_det_pin, .tsd_det_pin, .twarn_det_pin, .oc_det_pin,
      .hs_on_req, .retry_duty_sel, .fault_reset, .status0_ext, .status1_ext,
      .spi_miso, .spi_miso_oe, .hs_drive, .active_mode,
      .overcurrent_auto_retry_enable);
   spi_host_model u_host (.sys_clk, .start, .tx, .nbits,
      .spi_miso(miso_line), .spi_csn_pin, .spi_sclk_pin, .spi_mosi_pin,
      .rx, .done);
   task check(input [95:0] name, input [23:0] exp, input [23:0] got);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task frame(input [23:0] w, input [4:0] n);
      begin
         tx = w;
         nbits = n;
         start = 1'b1;
         @(posedge sys_clk) #1 start = 1'b0;
         wait (done === 1'b1);
      end
   endtask
   task pulse_reset;
      begin
         fault_reset = 1'b1;
         cyc(1);
         fault_reset = 1'b0;
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // Hang guard
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         summarize;
      end
   end
   // Main sequence
   initial begin
      {sys_clk, nrst, clk_en, miso_last, start} = 5'h04;
      {ov_det_pin, uv_det_pin, tsd_det_pin, twarn_det_pin} = 4'h0;
      {retry_duty_sel, fault_reset, oc_det_pin, hs_on_req} = 12'h000;
      {status0_ext, status1_ext, tx, nbits} = 68'h0;
      {bad_count, num_checks, cycles} = 96'h0;
      rows[0] = {24'h800001, 1'b1, 5'h00};
      rows[1] = {24'hFC0001, 1'b1, 5'h1F};
      rows[2] = {24'h940001, 1'b1, 5'h05};
      rows[3] = {24'hFC0000, 1'b1, 5'h05};
      rows[4] = {24'h7C0001, 1'b0, 5'h00};
      cyc(4);
      nrst = 1'b1;
      cyc(1);
      check("reset_out", 24'h0, {11'h0, active_mode,
         overcurrent_auto_retry_enable, hs_drive, spi_miso_oe, spi_miso});
      for (i = 0; i < 5; i = i + 1) begin
         frame(rows[i][29:6], 5'h18);
         check("mode_retry", {18'h0, rows[i][5:0]},
            {18'h0, active_mode, overcurrent_auto_retry_enable});
      end
      frame(24'h800001, 5'h18);
      frame(24'h800001, 5'h18);
      check("stat_nrdy", 24'h840000, rx);
      frame(24'hFC0001, 5'h18);
      check("stat_ready", 24'h800001, rx);
      check("frame_ok", 24'h1,
         {23'h0, rx !== 24'h0 && rx !== 24'hFFFFFF});
      hs_on_req = 5'h1F;
      cyc(4);
      check("drive_on", 24'h1F, {19'h0, hs_drive});
      for (i = 0; i < 2; i = i + 1) begin
         {uv_det_pin, ov_det_pin} = 2'h1 << i;
         cyc(10);
         check("drive_ovuv", 24'h0, {19'h0, hs_drive});
         {uv_det_pin, ov_det_pin} = 2'h0;
         cyc(10);
         check("drive_back", 24'h1F, {19'h0, hs_drive});
      end
      frame(24'hFC0001, 5'h18);
      check("stat_ovuv", 24'hE00000, rx);
      pulse_reset;
      tsd_det_pin = 1'b1;
      cyc(10);
      tsd_det_pin = 1'b0;
      cyc(10);
      check("drive_tsd", 24'h0, {19'h0, hs_drive});
      pulse_reset;
      cyc(4);
      check("drive_clr", 24'h1F, {19'h0, hs_drive});
      {twarn_det_pin, status1_ext} = {1'b1, 17'h00001};
      cyc(10);
      check("drive_warn", 24'h1F, {19'h0, hs_drive});
      frame(24'hFC0001, 5'h18);
      check("stat_warn", 24'h880002, rx);
      {twarn_det_pin, status1_ext} = 18'h0;
      // Over-current held across a retry, then removed
      oc_det_pin = 5'h01;
      cyc(30);
      oc_det_pin = 5'h00;
      cyc(40);
      check("drive_retry", 24'h1F, {19'h0, hs_drive});
      // Long duty: one short trip, output back after ten idle cycles
      retry_duty_sel = 1'b1;
      oc_det_pin = 5'h01;
      cyc(4);
      oc_det_pin = 5'h00;
      cyc(9);
      check("retry_wait", 24'h1E, {19'h0, hs_drive});
      cyc(8);
      check("retry_long", 24'h1F, {19'h0, hs_drive});
      frame(24'h000000, 5'h18);
      frame(24'hFC0001, 5'h18);
      check("stat_oc", 24'h802000, rx);
      pulse_reset;
      // Retry disabled: at most one phase retry, then held off
      frame(24'h800001, 5'h18);
      oc_det_pin = 5'h01;
      cyc(30);
      oc_det_pin = 5'h00;
      cyc(40);
      check("retry_off", 24'h1E, {19'h0, hs_drive});
      pulse_reset;
      cyc(4);
      check("oc_cleared", 24'h1F, {19'h0, hs_drive});
      // A 23-bit frame would set nonzero word one retry bits if it were taken
      frame(24'h3E0002, 5'h17);
      check("short_frame", 24'h000020,
         {18'h0, active_mode, overcurrent_auto_retry_enable});
      nrst = 1'b0;
      cyc(4);
      nrst = 1'b1;
      cyc(1);
      check("reset_again", 24'h0, {11'h0, active_mode,
         overcurrent_auto_retry_enable, hs_drive, spi_miso_oe, spi_miso});
      summarize;
   end
endmodule
